// File: rtl/asr_soft_reset_ctrl.sv
// per-channel soft-reset control for a two-channel delta-sigma digital core
// assumes modulator codes and filter results arrive synchronous to core_clk_in
`include "asr_cfg.svh"

// ----------------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------------
module asr_soft_reset_ctrl (
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_in,
    input  wire logic [1:0]             soft_reset_in,
    input  wire logic [1:0]             mod_out_en_in,
    input  wire logic [1:0]             mod_bit_in,
    input  wire logic [7:0]             phase_delay_in,
    input  wire logic [1:0]             frame_tick_in,
    input  wire logic [2*`ASR_DW-1:0]   filt_data_in,
    input  wire logic                   mclk_present_in,
    input  wire logic                   rd_ready_in,
    output logic [2*`ASR_DW-1:0]        data_out,
    output logic [1:0]                  data_ready_out,
    output logic [1:0]                  modulator_bitstream_out,
    output logic [1:0]                  modulator_bitstream_oe_n_out,
    output logic                        core_clk_en_out,
    output logic                        input_clk_en_out,
    output logic                        res_valid_out,
    output logic [`ASR_DW:0]            res_data_out
);
    // ------------------------------------------------------------------
    // per-channel state
    // ------------------------------------------------------------------
    asr_pkg::asr_state_t st_q [`ASR_NCH];
    logic [`ASR_DW-1:0]  dreg_q [`ASR_NCH];
    logic [1:0]          pat_q [`ASR_NCH];
    logic [7:0]          cnt_q [`ASR_NCH];
    logic [1:0]          drdy_q;
    logic [1:0]          mbit_q;
    logic [1:0]          oe_n_q;
    logic [1:0]          in_reset;
    logic [1:0]          run_tick;
    logic                ref_ch;
    logic                clk_en_q;
    logic                in_clk_q;

    asr_fifo_if #(.W(`ASR_DW + 1)) res_if ();

    assign ref_ch = ~in_reset[0] ? 1'b0 : 1'b1;

    genvar g;
    generate
        for (g = 0; g < `ASR_NCH; g++) begin : gen_ch
            localparam int OTHER = 1 - g;
            // zero pattern as a vector so one bit can be picked per cycle
            localparam logic [3:0] ZERO_PAT = `ASR_ZERO_PATTERN;
            // held in reset while own field bit is set
            assign in_reset[g] = soft_reset_in[g];
            // only running channels make results
            assign run_tick[g] = (st_q[g] == asr_pkg::ASR_RUN) & frame_tick_in[g];

            // state sequencer: hold, realign to running channel, settle, run
            always_ff @(posedge core_clk_in) begin
                if (rst_in) begin
                    st_q[g]  <= asr_pkg::ASR_RUN;
                    cnt_q[g] <= 8'h00;
                end else begin
                    case (st_q[g])
                        asr_pkg::ASR_RUN: begin
                            if (in_reset[g]) begin
                                st_q[g] <= asr_pkg::ASR_HOLD;
                            end
                        end
                        asr_pkg::ASR_HOLD: begin
                            if (!in_reset[g]) begin
                                // other channel live: wait its frame then settle
                                st_q[g]  <= in_reset[OTHER] ? asr_pkg::ASR_SETTLE
                                                             : asr_pkg::ASR_ALIGN;
                                cnt_q[g] <= in_reset[OTHER] ? `ASR_SINC_SETTLE
                                                             : phase_delay_in;
                            end
                        end
                        asr_pkg::ASR_ALIGN: begin
                            if (in_reset[g]) begin
                                st_q[g] <= asr_pkg::ASR_HOLD;
                            end else if (frame_tick_in[OTHER]) begin
                                st_q[g]  <= asr_pkg::ASR_SETTLE;
                                cnt_q[g] <= `ASR_SINC_SETTLE;
                            end
                        end
                        asr_pkg::ASR_SETTLE: begin
                            if (in_reset[g]) begin
                                st_q[g] <= asr_pkg::ASR_HOLD;
                            end else if (frame_tick_in[g]) begin
                                if (cnt_q[g] == 8'h00) begin
                                    st_q[g] <= asr_pkg::ASR_RUN;
                                end else begin
                                    cnt_q[g] <= cnt_q[g] - 8'h01;
                                end
                            end
                        end
                        default: st_q[g] <= asr_pkg::ASR_HOLD;
                    endcase
                end
            end

            // data register: cleared on entry, loaded only when running
            always_ff @(posedge core_clk_in) begin
                if (rst_in) begin
                    dreg_q[g] <= '0;
                end else if (in_reset[g]) begin
                    dreg_q[g] <= '0;
                end else if (run_tick[g]) begin
                    dreg_q[g] <= filt_data_in[g*`ASR_DW +: `ASR_DW];
                end
            end

            // data-ready pulse per result, never in reset
            always_ff @(posedge core_clk_in) begin
                if (rst_in) begin
                    drdy_q[g] <= 1'b0;
                end else begin
                    drdy_q[g] <= run_tick[g] & ~in_reset[g];
                end
            end

            // modulator pin: live code, or repeating zero pattern in reset
            always_ff @(posedge core_clk_in) begin
                if (rst_in) begin
                    pat_q[g]  <= 2'h0;
                    mbit_q[g] <= 1'b0;
                    oe_n_q[g] <= 1'b1;
                end else begin
                    pat_q[g]  <= pat_q[g] + 2'h1;
                    oe_n_q[g] <= ~mod_out_en_in[g];
                    if (in_reset[g]) begin
                        mbit_q[g] <= ZERO_PAT[2'h3 - pat_q[g]];
                    end else begin
                        mbit_q[g] <= mod_bit_in[g];
                    end
                end
            end

            // channel stays in hold for whole reset
            hold_clear_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                in_reset[g] |=> dreg_q[g] == '0)
                else $error("data register not cleared in reset");
            no_drdy_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                in_reset[g] ##1 in_reset[g] |-> !drdy_q[g])
                else $error("data ready during soft reset");
            enter_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                (st_q[g] == asr_pkg::ASR_RUN && in_reset[g])
                |=> st_q[g] == asr_pkg::ASR_HOLD)
                else $error("soft reset not entered");
            stay_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                (st_q[g] == asr_pkg::ASR_HOLD && in_reset[g])
                |=> st_q[g] == asr_pkg::ASR_HOLD)
                else $error("left soft reset without clear");
            pin_oe_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                1'b1 |=> oe_n_q[g] == !$past(mod_out_en_in[g]))
                else $error("modulator output enable wrong");

            // ----------------------------------------------------------
            // exit sequencing checks
            // ----------------------------------------------------------
            // channel is in hold and its field bit has just been cleared
            sequence ch_leaving_s;
                st_q[g] == asr_pkg::ASR_HOLD && !in_reset[g];
            endsequence

            // the other channel is converting
            sequence partner_live_s;
                !in_reset[OTHER];
            endsequence

            // leaving hold never goes straight to run: settling comes first
            exit_go_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                ch_leaving_s
                |=> (st_q[g] == asr_pkg::ASR_ALIGN || st_q[g] == asr_pkg::ASR_SETTLE))
                else $error("soft reset exit skipped settling");

            // with the partner live the exit realigns against its frames
            exit_align_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                (ch_leaving_s and partner_live_s) |=> st_q[g] == asr_pkg::ASR_ALIGN)
                else $error("exit did not realign to running channel");

            // programmed phase is carried into the realignment
            phase_keep_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                (ch_leaving_s and partner_live_s) |=> cnt_q[g] == $past(phase_delay_in))
                else $error("phase delay not kept across soft reset");

            // alignment waits for a frame of the running channel
            align_wait_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                (st_q[g] == asr_pkg::ASR_ALIGN && !in_reset[g] && !frame_tick_in[OTHER])
                |=> st_q[g] == asr_pkg::ASR_ALIGN)
                else $error("alignment left without partner frame");

            // settling counts own frames down by one each
            settle_count_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                (st_q[g] == asr_pkg::ASR_SETTLE && !in_reset[g] && frame_tick_in[g]
                 && cnt_q[g] != 8'h00)
                |=> cnt_q[g] == $past(cnt_q[g]) - 8'h01)
                else $error("settling count wrong");

            // settling holds without own frames
            settle_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                (st_q[g] == asr_pkg::ASR_SETTLE && !in_reset[g] && !frame_tick_in[g])
                |=> st_q[g] == asr_pkg::ASR_SETTLE)
                else $error("settling ended without a frame");

            // ----------------------------------------------------------
            // data path checks
            // ----------------------------------------------------------
            // held channel shows zero throughout its hold
            hold_zero_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                st_q[g] == asr_pkg::ASR_HOLD |-> dreg_q[g] == '0)
                else $error("output not zero while held");

            // a running frame loads the filter result
            run_load_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                (run_tick[g] && !in_reset[g])
                |=> dreg_q[g] == $past(filt_data_in[g*`ASR_DW +: `ASR_DW]))
                else $error("running result not loaded");

            // holding this channel leaves the other's data alone
            other_kept_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                (in_reset[g] && !in_reset[OTHER] && !run_tick[OTHER])
                |=> $stable(dreg_q[OTHER]))
                else $error("other channel data disturbed");

            // live modulator code passes through when not held
            live_bit_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                !in_reset[g] |=> mbit_q[g] == $past(mod_bit_in[g]))
                else $error("live modulator bit not passed");

            // held channel sends the zero pattern bit for its phase
            pat_bit_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
                in_reset[g] |=> mbit_q[g] == ZERO_PAT[2'h3 - $past(pat_q[g])])
                else $error("zero pattern bit wrong");
        end
    endgenerate

    // ------------------------------------------------------------------
    // clock gating
    // ------------------------------------------------------------------
    // core clock stops only with both channels held
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            clk_en_q <= 1'b1;
        end else begin
            clk_en_q <= ~(in_reset[0] & in_reset[1]);
        end
    end

    // input structure clocked whenever master clock runs
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            in_clk_q <= 1'b0;
        end else begin
            in_clk_q <= mclk_present_in;
        end
    end

    // ------------------------------------------------------------------
    // result fifo: channel tag plus sample of reference channel
    // ------------------------------------------------------------------
    assign res_if.valid = run_tick[ref_ch];
    assign res_if.data  = {ref_ch, filt_data_in[ref_ch*`ASR_DW +: `ASR_DW]};

    asr_fifo #(
        .WIDTH (`ASR_DW + 1),
        .DEPTH (`ASR_FIFO_DEPTH)
    ) u_fifo (
        .clk_in       (core_clk_in),
        .rst_in       (rst_in),
        .wr           (res_if),
        .rd_valid_out (res_valid_out),
        .rd_ready_in  (rd_ready_in),
        .rd_data_out  (res_data_out)
    );

    // outputs from flops
    assign data_out                     = {dreg_q[1], dreg_q[0]};
    assign data_ready_out               = drdy_q;
    assign modulator_bitstream_out      = mbit_q;
    assign modulator_bitstream_oe_n_out = oe_n_q;
    assign core_clk_en_out              = clk_en_q;
    assign input_clk_en_out             = in_clk_q;

    both_gate_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (in_reset == 2'h3) |=> !core_clk_en_out)
        else $error("core clock not gated");
    one_run_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (in_reset != 2'h3) |=> core_clk_en_out)
        else $error("core clock stopped with a channel live");
    input_clk_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        mclk_present_in |=> input_clk_en_out)
        else $error("input structure clock lost");
    // input clock stops when the master clock is absent
    input_clk_off_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !mclk_present_in |=> !input_clk_en_out)
        else $error("input structure clock without master clock");
endmodule

// File: rtl/asr_cfg.svh
// constants for the per-channel soft-reset control
// assumes inclusion by bare name from any rtl file
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH
`define ASR_NCH            2
`define ASR_DW             24
`define ASR_ZERO_PATTERN   4'h3
`define ASR_PAT_LEN        4
`define ASR_FIFO_DEPTH     4
`define ASR_SINC_SETTLE    8'h03
`define ASR_DRDY_RESET     1'h1
`endif

// File: rtl/asr_pkg.sv
// types for the per-channel soft-reset control
// assumes the constants header is compiled alongside
package asr_pkg;
    typedef enum logic [1:0] {
        ASR_RUN    = 2'h0,
        ASR_HOLD   = 2'h1,
        ASR_ALIGN  = 2'h3,
        ASR_SETTLE = 2'h2
    } asr_state_t;
endpackage

// File: rtl/asr_fifo_if.sv
// handshake bundle between the control core and its result fifo
// assumes one clock domain
interface asr_fifo_if #(parameter int W = 25);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: rtl/asr_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes a single clock and synchronous active-high reset
module asr_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    asr_fifo_if.snk               wr,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in,
    output logic [WIDTH-1:0]      rd_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // honest full and empty from the occupancy count
    assign wr.ready     = (cnt_q != DEPTH[AW:0]);
    assign rd_valid_out = (cnt_q != '0);
    assign rd_data_out  = mem_q[rp_q];
    assign push         = wr.valid && wr.ready;
    assign pop          = rd_valid_out && rd_ready_in;

    // storage write
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wp_q] <= wr.data;
        end
    end

    // pointers and count
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// File: test/tb_top.sv
// self-checking bench for the per-channel soft-reset control
// assumes rtl files compiled first and the constants header on the include path
`include "asr_cfg.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // stimulus and observation signals
    // ------------------------------------------------------------------
    logic                   core_clk_in   = 1'b0;
    logic                   rst_in        = 1'b1;
    logic [1:0]             soft_reset_in = 2'h0;
    logic [1:0]             mod_out_en_in = 2'h3;
    logic [1:0]             mod_bit_in    = 2'h0;
    logic [7:0]             phase_delay_in = 8'h05;
    logic [1:0]             frame_tick_in = 2'h0;
    logic [2*`ASR_DW-1:0]   filt_data_in  = '0;
    logic                   mclk_present_in = 1'b1;
    logic                   rd_ready_in   = 1'b1;
    logic [2*`ASR_DW-1:0]   data_out;
    logic [1:0]             data_ready_out;
    logic [1:0]             bs_out;
    logic [1:0]             bs_oe_n;
    logic                   core_en;
    logic                   input_en;
    logic                   res_valid;
    logic [`ASR_DW:0]       res_data;
    integer                 seed = 32'h9BB0;
    integer                 fails = 0;
    integer                 n_checks = 0;
    logic [`ASR_DW-1:0]     smp [0:5];

    asr_soft_reset_ctrl dut (
        .core_clk_in                  (core_clk_in),
        .rst_in                       (rst_in),
        .soft_reset_in                (soft_reset_in),
        .mod_out_en_in                (mod_out_en_in),
        .mod_bit_in                   (mod_bit_in),
        .phase_delay_in               (phase_delay_in),
        .frame_tick_in                (frame_tick_in),
        .filt_data_in                 (filt_data_in),
        .mclk_present_in              (mclk_present_in),
        .rd_ready_in                  (rd_ready_in),
        .data_out                     (data_out),
        .data_ready_out               (data_ready_out),
        .modulator_bitstream_out      (bs_out),
        .modulator_bitstream_oe_n_out (bs_oe_n),
        .core_clk_en_out              (core_en),
        .input_clk_en_out             (input_en),
        .res_valid_out                (res_valid),
        .res_data_out                 (res_data)
    );

    // 40 MHz clock and a live random modulator stream
    always #12.5 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        mod_bit_in <= 2'($random(seed));
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic test_done();
        if (fails == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // wait edges, then let the edge's updates settle
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask

    // one-cycle filter tick per channel mask; leaves outputs settled after the take edge
    task automatic tick(input logic [1:0] m, input logic [2*`ASR_DW-1:0] d);
        @(posedge core_clk_in);
        frame_tick_in <= m;
        filt_data_in  <= d;
        @(posedge core_clk_in);
        frame_tick_in <= 2'h0;
        #1;
    endtask

    // the captured stream must repeat the zero pattern at some rotation
    function automatic logic pat_ok(input logic [7:0] v);
        logic [3:0] p;
        logic       ok;
        p  = `ASR_ZERO_PATTERN;
        ok = 1'b0;
        for (int r = 0; r < 4; r++) begin
            if (v[7:4] == p) ok = 1'b1;
            p = {p[2:0], p[3]};
        end
        return ok && (v[7:4] == v[3:0]);
    endfunction

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [2*`ASR_DW-1:0] d;
        logic [7:0]           v;
        int                   k;
        int                   cnt;
        step(5);
        rst_in <= 1'b0;
        step(1);
        check("rst data", data_out, 0);
        check("rst oe_n", bs_oe_n, 2'h0);
        // both running: random samples land with a ready pulse
        for (int i = 0; i < 6; i++) begin
            d = {$random(seed), $random(seed)};
            tick(2'h3, d);
            check("run drdy", data_ready_out, 2'h3);
            check("run data", data_out, d);
        end
        // channel zero into soft reset, channel one untouched
        @(posedge core_clk_in);
        soft_reset_in <= 2'h1;
        step(2);
        check("hold data0", data_out[`ASR_DW-1:0], 0);
        check("hold data1", data_out[2*`ASR_DW-1:`ASR_DW], d[2*`ASR_DW-1:`ASR_DW]);
        check("core en one held", core_en, 1'b1);
        tick(2'h3, {$random(seed), $random(seed)});
        check("hold drdy", data_ready_out, 2'h2);
        check("hold out0", data_out[`ASR_DW-1:0], 0);
        v = 8'h00;
        for (int i = 0; i < 8; i++) begin
            step(1);
            v = {v[6:0], bs_out[0]};
        end
        check("pattern", pat_ok(v), 1'b1);
        check("pin driven", bs_oe_n[0], 1'b0);
        // both held: core clock gated, input clock follows master clock
        @(posedge core_clk_in);
        soft_reset_in <= 2'h3;
        step(3);
        check("core en both", core_en, 1'b0);
        check("input en", input_en, 1'b1);
        @(posedge core_clk_in);
        mclk_present_in <= 1'b0;
        step(3);
        check("input en off", input_en, 1'b0);
        @(posedge core_clk_in);
        mclk_present_in <= 1'b1;
        soft_reset_in   <= 2'h1;
        step(3);
        check("core en back", core_en, 1'b1);
        // bring channel one back to running
        k = 0;
        while (k < 10 && data_ready_out[1] !== 1'b1) begin
            step(2);
            tick(2'h2, {$random(seed), $random(seed)});
            k++;
        end
        check("ch1 restart", k < 10, 1'b1);
        // channel zero exits: waits for channel one, then settles
        @(posedge core_clk_in);
        soft_reset_in <= 2'h0;
        step(2);
        tick(2'h1, {$random(seed), $random(seed)});
        check("align no drdy", data_ready_out[0], 1'b0);
        step(3);
        tick(2'h2, {$random(seed), $random(seed)});
        k = 0;
        while (k < 10 && data_ready_out[0] !== 1'b1) begin
            step(3);
            tick(2'h1, {$random(seed), $random(seed)});
            k++;
        end
        check("settle ticks", k, `ASR_SINC_SETTLE + 2);
        // drain, then fill the fifo past its depth with the far side stalled
        step(8);
        @(posedge core_clk_in);
        rd_ready_in <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            smp[i] = `ASR_DW'($random(seed));
            tick(2'h1, {`ASR_DW'(0), smp[i]});
            step(2);
        end
        cnt = 0;
        @(posedge core_clk_in);
        rd_ready_in <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            #1;
            if (res_valid === 1'b1) begin
                if (cnt < 4) check("fifo word", res_data, {1'b0, smp[cnt]});
                cnt++;
            end
            @(posedge core_clk_in);
        end
        check("fifo count", cnt, `ASR_FIFO_DEPTH);
        test_done();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk_in);
        fails = fails + 1;
        test_done();
    end
endmodule
